// [common/clt_pkg.sv]
// Shared constants and carrier types of the camera link tap mapper.
// Assumes a single 100 MHz system clock; every external line is asynchronous to it.
package clt_pkg;

  // ****************************************
  // Clock and serial timing
  // ****************************************
  localparam int CLT_CLK_HZ = 100_000_000;
  localparam int CLT_CLK_PERIOD_NS = 10;
  localparam int CLT_BAUD_DEFAULT = 9600;
  localparam int CLT_BAUD_CNT_W = 20;
  localparam int CLT_UART_DATA_W = 8;
  localparam int CLT_UART_FRAME_W = 10;
  localparam logic CLT_UART_IDLE = 1'b1;
  localparam logic CLT_UART_START = 1'b0;
  localparam logic CLT_UART_STOP = 1'b1;

  // ****************************************
  // Pixel and port layout
  // ****************************************
  localparam int CLT_TAPS = 4;
  localparam int CLT_TAP_W = 10;
  localparam int CLT_LO_W = 8;
  localparam int CLT_HI_W = 2;
  localparam int CLT_PORT_W = 8;
  localparam int CLT_HI_LSB_T1 = 0;
  localparam int CLT_HI_LSB_T2 = 4;
  localparam int CLT_HI_LSB_T3 = 0;
  localparam int CLT_HI_LSB_T4 = 4;
  localparam int CLT_FIFO_DEPTH = 16;
  localparam logic CLT_FIXED_HIGH = 1'b1;

  // ****************************************
  // Input synchroniser slots
  // ****************************************
  localparam int CLT_SYNC_N = 4;
  localparam int CLT_SYNC_PCLK = 0;
  localparam int CLT_SYNC_PWR = 1;
  localparam int CLT_SYNC_CC = 2;
  localparam int CLT_SYNC_RX = 3;
  // Reset to each line's idle level: pixel clock low, triggers and serial high, so no false edge follows reset
  localparam logic [CLT_SYNC_N-1:0] CLT_SYNC_RST = 4'he;

  typedef enum logic [1:0] {
    CLT_TAP1 = 2'b00,
    CLT_TAP2 = 2'b01,
    CLT_TAP4 = 2'b10
  } clt_tap_cfg_e;

  typedef enum logic [1:0] {
    CLT_RX_IDLE = 2'b00,
    CLT_RX_START = 2'b01,
    CLT_RX_DATA = 2'b10,
    CLT_RX_STOP = 2'b11
  } clt_rx_state_e;

  typedef enum logic {
    CLT_TX_IDLE = 1'b0,
    CLT_TX_SHIFT = 1'b1
  } clt_tx_state_e;

  typedef struct packed {
    logic fval;
    logic lval;
    logic [CLT_TAPS-1:0][CLT_TAP_W-1:0] tap;
  } clt_pix_word_s;

  typedef struct packed {
    logic fval;
    logic lval;
    logic [CLT_PORT_W-1:0] a;
    logic [CLT_PORT_W-1:0] b;
    logic [CLT_PORT_W-1:0] c;
    logic [CLT_PORT_W-1:0] d;
    logic [CLT_PORT_W-1:0] e;
    logic [CLT_PORT_W-1:0] f;
  } clt_link_ports_s;

endpackage

// [hdl/clt_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module clt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Extra pointer bit separates full from empty
  assign out_valid = wr_q != rd_q;
  assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hdl/clt_tap_mapper.sv]
// Camera link output mapper: taps to ports, control bits, UART lines, shutter trigger.
// Assumes the pixel clock, triggers and serial input arrive asynchronously to clk_sys.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Strobe follows pixel clock; line and frame valid sent; data valid and spare stay high.
// - 8-bit mode: tap bits 0..7 go to ports A, B, C, D; unused low.
// - 10-bit mode: low bytes to A, C, E, D; high pairs to B0, B4, F0, F4.
// - Response bytes leave on the grabber serial line with standard UART framing.
// - Control lines CC2, CC3 and CC4 are reserved and change nothing.
// - Shutter trigger accepted on power-connector input and on link line CC1.
// - Four taps use medium configuration; one and two taps use base only.
// - Triggers combine as active-low OR; shutter starts on combined trailing edge.
module clt_tap_mapper
  import clt_pkg::*;
#(
  parameter int BAUD = CLT_BAUD_DEFAULT,
  parameter int FIFO_DEPTH = CLT_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire clt_pix_word_s pix_word,
  input wire logic mode_10bit,
  input wire clt_tap_cfg_e tap_cfg,
  input wire logic link_clk_in,
  output logic link_strobe,
  output clt_link_ports_s link_ports,
  output logic link_dval,
  output logic link_spare,
  output logic medium_cfg,
  input wire logic trigger_in_power_conn_n,
  input wire logic trigger_in_link_cc_n,
  input wire logic [2:0] cc_reserved,
  output logic shutter_start,
  input wire logic serial_to_camera,
  output logic serial_to_grabber,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [CLT_UART_DATA_W-1:0] tx_data,
  output logic rx_valid,
  output logic [CLT_UART_DATA_W-1:0] rx_data,
  output logic rx_frame_err
);
  localparam logic [CLT_BAUD_CNT_W-1:0] BIT_CYC = CLT_BAUD_CNT_W'(CLT_CLK_HZ / BAUD);
  localparam logic [CLT_BAUD_CNT_W-1:0] HALF_CYC = CLT_BAUD_CNT_W'(CLT_CLK_HZ / BAUD / 2);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [CLT_SYNC_N-1:0] s1_q, s2_q, s3_q, stable_q, chg;
  logic pclk_rise;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= CLT_SYNC_RST;
      s2_q <= CLT_SYNC_RST;
      s3_q <= CLT_SYNC_RST;
    end else begin
      s1_q <= {serial_to_camera, trigger_in_link_cc_n, trigger_in_power_conn_n, link_clk_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A level counts once the last two stages agree, so a single metastable sample never moves it
  genvar gi;
  for (gi = 0; gi < CLT_SYNC_N; gi++) begin : g_sync
    assign chg[gi] = (s2_q[gi] == s3_q[gi]) && (s3_q[gi] != stable_q[gi]);
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        stable_q[gi] <= CLT_SYNC_RST[gi];
      end else if (chg[gi]) begin
        stable_q[gi] <= s3_q[gi];
      end
    end
  end

  assign pclk_rise = chg[CLT_SYNC_PCLK] && s3_q[CLT_SYNC_PCLK];

  // ****************************************
  // Pixel buffer and port mapping
  // ****************************************
  clt_pix_word_s fifo_word;
  logic fifo_valid;
  clt_link_ports_s ports_q;
  logic strobe_q, medium_q;

  clt_fifo #(.WIDTH($bits(clt_pix_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_word),
    .out_valid(fifo_valid),
    .out_ready(pclk_rise),
    .out_data(fifo_word)
  );

  function automatic clt_link_ports_s map_word(clt_pix_word_s w, logic m10, clt_tap_cfg_e cfg);
    clt_link_ports_s p;
    logic [CLT_TAPS-1:0][CLT_TAP_W-1:0] t;
    p = '0;
    t = w.tap;
    // Taps beyond the configured count are forced to zero so their ports stay low
    if (cfg == CLT_TAP1) begin
      t[1] = '0;
    end
    if (cfg != CLT_TAP4) begin
      t[2] = '0;
      t[3] = '0;
    end
    p.fval = w.fval;
    p.lval = w.lval;
    if (!m10) begin
      p.a = t[0][CLT_LO_W-1:0];
      p.b = t[1][CLT_LO_W-1:0];
      p.c = t[2][CLT_LO_W-1:0];
      p.d = t[3][CLT_LO_W-1:0];
    end else begin
      p.a = t[0][CLT_LO_W-1:0];
      p.c = t[1][CLT_LO_W-1:0];
      p.e = t[2][CLT_LO_W-1:0];
      p.d = t[3][CLT_LO_W-1:0];
      p.b[CLT_HI_LSB_T1 +: CLT_HI_W] = t[0][CLT_TAP_W-1:CLT_LO_W];
      p.b[CLT_HI_LSB_T2 +: CLT_HI_W] = t[1][CLT_TAP_W-1:CLT_LO_W];
      p.f[CLT_HI_LSB_T3 +: CLT_HI_W] = t[2][CLT_TAP_W-1:CLT_LO_W];
      p.f[CLT_HI_LSB_T4 +: CLT_HI_W] = t[3][CLT_TAP_W-1:CLT_LO_W];
    end
    return p;
  endfunction

  // Whole link word changes at once; an empty buffer sends an idle word with both valids low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ports_q <= '0;
    end else if (pclk_rise) begin
      ports_q <= fifo_valid ? map_word(fifo_word, mode_10bit, tap_cfg) : '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strobe_q <= 1'b0;
      medium_q <= 1'b0;
    end else begin
      strobe_q <= stable_q[CLT_SYNC_PCLK];
      medium_q <= tap_cfg == CLT_TAP4;
    end
  end

  assign link_ports = ports_q;
  assign link_strobe = strobe_q;
  assign medium_cfg = medium_q;
  assign link_dval = CLT_FIXED_HIGH;
  assign link_spare = CLT_FIXED_HIGH;

  // ****************************************
  // Shutter trigger
  // ****************************************
  logic trig_now, trig_active_q, shutter_q;

  // Either low input is active; a stuck-active input masks every trailing edge
  assign trig_now = !stable_q[CLT_SYNC_PWR] || !stable_q[CLT_SYNC_CC];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_active_q <= 1'b0;
      shutter_q <= 1'b0;
    end else begin
      trig_active_q <= trig_now;
      shutter_q <= trig_active_q && !trig_now;
    end
  end

  assign shutter_start = shutter_q;

  // ****************************************
  // UART transmitter
  // ****************************************
  clt_tx_state_e tx_state_q;
  logic [CLT_UART_FRAME_W-1:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [CLT_BAUD_CNT_W-1:0] tx_cnt_q;
  logic tx_line_q;

  assign tx_ready = tx_state_q == CLT_TX_IDLE;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_state_q <= CLT_TX_IDLE;
      tx_sh_q <= '1;
      tx_bits_q <= '0;
      tx_cnt_q <= '0;
      tx_line_q <= CLT_UART_IDLE;
    end else begin
      case (tx_state_q)
        CLT_TX_IDLE: begin
          tx_line_q <= CLT_UART_IDLE;
          if (tx_valid) begin
            tx_sh_q <= {CLT_UART_STOP, tx_data, CLT_UART_START};
            tx_bits_q <= '0;
            tx_cnt_q <= '0;
            tx_state_q <= CLT_TX_SHIFT;
          end
        end
        CLT_TX_SHIFT: begin
          tx_line_q <= tx_sh_q[0];
          if (tx_cnt_q == BIT_CYC - 1'b1) begin
            tx_cnt_q <= '0;
            tx_sh_q <= {CLT_UART_IDLE, tx_sh_q[CLT_UART_FRAME_W-1:1]};
            if (tx_bits_q == 4'(CLT_UART_FRAME_W - 1)) begin
              tx_state_q <= CLT_TX_IDLE;
            end else begin
              tx_bits_q <= tx_bits_q + 1'b1;
            end
          end else begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
          end
        end
        default: tx_state_q <= CLT_TX_IDLE;
      endcase
    end
  end

  assign serial_to_grabber = tx_line_q;

  // ****************************************
  // UART receiver
  // ****************************************
  clt_rx_state_e rx_state_q;
  logic [CLT_BAUD_CNT_W-1:0] rx_cnt_q;
  logic [3:0] rx_bits_q;
  logic [CLT_UART_DATA_W-1:0] rx_sh_q, rx_data_q;
  logic rx_valid_q, rx_err_q;
  logic rx_line;

  // Sampling at mid-bit tolerates baud mismatch on the grabber side
  assign rx_line = stable_q[CLT_SYNC_RX];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_state_q <= CLT_RX_IDLE;
      rx_cnt_q <= '0;
      rx_bits_q <= '0;
      rx_sh_q <= '0;
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
      rx_cnt_q <= rx_cnt_q + 1'b1;
      case (rx_state_q)
        CLT_RX_IDLE: begin
          rx_cnt_q <= '0;
          if (rx_line == CLT_UART_START) begin
            rx_state_q <= CLT_RX_START;
          end
        end
        CLT_RX_START: begin
          if (rx_cnt_q == HALF_CYC) begin
            rx_cnt_q <= '0;
            rx_bits_q <= '0;
            rx_state_q <= (rx_line == CLT_UART_START) ? CLT_RX_DATA : CLT_RX_IDLE;
          end
        end
        CLT_RX_DATA: begin
          if (rx_cnt_q == BIT_CYC - 1'b1) begin
            rx_cnt_q <= '0;
            rx_sh_q <= {rx_line, rx_sh_q[CLT_UART_DATA_W-1:1]};
            rx_bits_q <= rx_bits_q + 1'b1;
            if (rx_bits_q == 4'(CLT_UART_DATA_W - 1)) begin
              rx_state_q <= CLT_RX_STOP;
            end
          end
        end
        CLT_RX_STOP: begin
          if (rx_cnt_q == BIT_CYC - 1'b1) begin
            rx_data_q <= rx_sh_q;
            rx_valid_q <= rx_line == CLT_UART_STOP;
            rx_err_q <= rx_line != CLT_UART_STOP;
            rx_state_q <= CLT_RX_IDLE;
          end
        end
        default: rx_state_q <= CLT_RX_IDLE;
      endcase
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
  assign rx_frame_err = rx_err_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_fixed_high;
    @(posedge clk_sys) disable iff (rst) link_dval && link_spare && (link_strobe == $past(stable_q[CLT_SYNC_PCLK]));
  endproperty
  a_fixed_high: assert property (p_fixed_high) else $error("dval, spare or strobe wrong");

  property p_map8;
    @(posedge clk_sys) disable iff (rst) pclk_rise && fifo_valid && !mode_10bit && tap_cfg == CLT_TAP4 |=>
      link_ports.a == $past(fifo_word.tap[0][CLT_LO_W-1:0]) && link_ports.d == $past(fifo_word.tap[3][CLT_LO_W-1:0])
      && link_ports.e == '0 && link_ports.f == '0;
  endproperty
  a_map8: assert property (p_map8) else $error("8-bit tap mapping wrong");

  property p_map10;
    @(posedge clk_sys) disable iff (rst) pclk_rise && fifo_valid && mode_10bit && tap_cfg == CLT_TAP4 |=>
      link_ports.e == $past(fifo_word.tap[2][CLT_LO_W-1:0])
      && link_ports.b[CLT_HI_LSB_T2 +: CLT_HI_W] == $past(fifo_word.tap[1][CLT_TAP_W-1:CLT_LO_W])
      && link_ports.f[CLT_HI_LSB_T4 +: CLT_HI_W] == $past(fifo_word.tap[3][CLT_TAP_W-1:CLT_LO_W]);
  endproperty
  a_map10: assert property (p_map10) else $error("10-bit tap mapping wrong");

  property p_base_cfg;
    @(posedge clk_sys) disable iff (rst) pclk_rise && tap_cfg != CLT_TAP4 |=>
      link_ports.d == '0 && link_ports.e == '0 && link_ports.f == '0 && !medium_cfg;
  endproperty
  a_base_cfg: assert property (p_base_cfg) else $error("base configuration drives medium ports");

  property p_word_together;
    @(posedge clk_sys) disable iff (rst) !pclk_rise |=> $stable(link_ports);
  endproperty
  a_word_together: assert property (p_word_together) else $error("link word changed off pixel edge");

  property p_tx_start;
    @(posedge clk_sys) disable iff (rst) tx_valid && tx_ready |=> ##1 !serial_to_grabber [*8];
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit missing");

  property p_tx_idle;
    @(posedge clk_sys) disable iff (rst) $past(tx_ready) && tx_ready |-> serial_to_grabber;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("serial line not idle high");

  property p_trailing;
    @(posedge clk_sys) disable iff (rst) shutter_start == $fell(trig_active_q);
  endproperty
  a_trailing: assert property (p_trailing) else $error("shutter not on trailing edge");

  property p_cc1_trigger;
    @(posedge clk_sys) disable iff (rst)
      $rose(stable_q[CLT_SYNC_CC]) && stable_q[CLT_SYNC_PWR] && $past(stable_q[CLT_SYNC_PWR]) |=> shutter_start;
  endproperty
  a_cc1_trigger: assert property (p_cc1_trigger) else $error("link trigger ignored");
endmodule
`default_nettype wire

// [verif/clt_grabber_model.sv]
// Capture-board model: pixel clock, link trigger line and both serial lines.
// Assumes a 1 us bit time (BAUD of 1_000_000) and an 80 ns pixel clock.
`timescale 1ns/1ps
`default_nettype none
module clt_grabber_model (
  output var logic link_clk_in,
  output var logic trigger_in_link_cc_n,
  output var logic serial_to_camera,
  input wire logic serial_to_grabber
);
  localparam int BIT_NS = 1000;

  initial begin
    link_clk_in = 1'b0;
    trigger_in_link_cc_n = 1'b1;
    serial_to_camera = 1'b1;
  end

  // ****************************************
  // Pixel clock, only while a beat is wanted
  // ****************************************
  // Offset from system clock edges so no pixel clock edge lands on one
  task automatic pclk();
    #3 link_clk_in = 1'b1;
    #40 link_clk_in = 1'b0;
    #37;
  endtask

  task automatic set_cc(input logic v);
    trigger_in_link_cc_n = v;
  endtask

  // ****************************************
  // Serial lines, 8N1, LSB first
  // ****************************************
  // A low stop bit is the only wrong frame the model makes
  task automatic send(input logic [7:0] b, input logic stop_bit);
    serial_to_camera = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      serial_to_camera = b[i];
      #BIT_NS;
    end
    serial_to_camera = stop_bit;
    #BIT_NS;
    serial_to_camera = 1'b1;
    #(2 * BIT_NS);
  endtask

  task automatic get(output logic [7:0] b, output logic stop);
    b = 8'h00;
    wait (serial_to_grabber === 1'b0);
    #(BIT_NS + BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = serial_to_grabber;
      #BIT_NS;
    end
    stop = serial_to_grabber;
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the tap mapper with a capture-board model.
// Assumes a 100 MHz clk_sys and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clt_pkg::*;
  localparam int BAUD = 1_000_000;
  logic clk_sys, rst, pix_valid, pix_ready, mode_10bit, link_strobe;
  clt_pix_word_s pix_word;
  clt_tap_cfg_e tap_cfg;
  clt_link_ports_s link_ports;
  logic link_dval, link_spare, medium_cfg, trigger_in_power_conn_n, shutter_start;
  logic [2:0] cc_reserved;
  logic serial_to_grabber, tx_valid, tx_ready, rx_valid, rx_frame_err;
  logic [7:0] tx_data, rx_data, rx_last;
  wire logic link_clk_in, trigger_in_link_cc_n, serial_to_camera;
  int n_fail = 0, tests_run = 0, n_shot = 0, n_rx = 0, n_err = 0;

  clt_tap_mapper #(.BAUD(BAUD), .FIFO_DEPTH(CLT_FIFO_DEPTH)) uut (
    .clk_sys(clk_sys), .rst(rst), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_word(pix_word), .mode_10bit(mode_10bit), .tap_cfg(tap_cfg),
    .link_clk_in(link_clk_in), .link_strobe(link_strobe), .link_ports(link_ports),
    .link_dval(link_dval), .link_spare(link_spare), .medium_cfg(medium_cfg),
    .trigger_in_power_conn_n(trigger_in_power_conn_n),
    .trigger_in_link_cc_n(trigger_in_link_cc_n), .cc_reserved(cc_reserved),
    .shutter_start(shutter_start), .serial_to_camera(serial_to_camera),
    .serial_to_grabber(serial_to_grabber), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_err(rx_frame_err)
  );

  clt_grabber_model grabber (
    .link_clk_in(link_clk_in), .trigger_in_link_cc_n(trigger_in_link_cc_n),
    .serial_to_camera(serial_to_camera), .serial_to_grabber(serial_to_grabber)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Counting every high cycle also catches a pulse longer than one cycle
  always @(posedge clk_sys) begin
    if (shutter_start === 1'b1) n_shot++;
    if (rx_valid === 1'b1) begin
      n_rx++;
      rx_last = rx_data;
    end
    if (rx_frame_err === 1'b1) n_err++;
  end

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic clt_pix_word_s mk(input int k);
    clt_pix_word_s w;
    w.fval = 1'b1;
    w.lval = 1'(k);
    for (int i = 0; i < 4; i++) w.tap[i] = 10'(k * 97 + i * 301 + 13);
    return w;
  endfunction

  function automatic clt_link_ports_s exp_map(input clt_pix_word_s w, input logic m, input int c);
    clt_link_ports_s p;
    p = '0;
    p.fval = w.fval;
    p.lval = w.lval;
    if (c == 0) w.tap[1] = '0;
    if (c != 2) begin
      w.tap[2] = '0;
      w.tap[3] = '0;
    end
    if (!m) begin
      {p.d, p.c, p.b, p.a} = {w.tap[3][7:0], w.tap[2][7:0], w.tap[1][7:0], w.tap[0][7:0]};
    end else begin
      {p.a, p.c, p.e, p.d} = {w.tap[0][7:0], w.tap[1][7:0], w.tap[2][7:0], w.tap[3][7:0]};
      p.b = {2'b00, w.tap[1][9:8], 2'b00, w.tap[0][9:8]};
      p.f = {2'b00, w.tap[3][9:8], 2'b00, w.tap[2][9:8]};
    end
    return p;
  endfunction

  // Valid stays high on return so pushes can run back to back
  task automatic push(input clt_pix_word_s w);
    logic taken;
    taken = 1'b0;
    pix_word = w;
    pix_valid = 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (pix_ready === 1'b1) begin
        taken = 1'b1;
        break;
      end
    end
    #1;
    chk("pix_taken", 64'(taken), 64'h1);
  endtask

  // Start every beat at the same phase so no pixel clock edge lands on a system clock edge
  task automatic beat(input clt_link_ports_s e);
    cyc(1);
    fork
      grabber.pclk();
      begin
        #63 chk("strobe_high", 64'(link_strobe), 64'h1);
        #70 chk("strobe_low", 64'(link_strobe), 64'h0);
      end
    join
    chk("link_ports", 64'(link_ports), 64'(e));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("dval", 64'(link_dval), 64'h1);
    chk("spare", 64'(link_spare), 64'h1);
    chk("ports_rst", 64'(link_ports), 64'h0);
    chk("tx_idle", 64'(serial_to_grabber), 64'h1);
  endtask

  task automatic t_map();
    clt_pix_word_s w;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 3; c++) begin
        mode_10bit = 1'(m);
        tap_cfg = clt_tap_cfg_e'(2'(c));
        w = mk(m * 3 + c + 1);
        push(w);
        pix_valid = 1'b0;
        cyc(2);
        beat(exp_map(w, 1'(m), c));
        chk("medium_cfg", 64'(medium_cfg), 64'(c == 2));
      end
    end
  endtask

  task automatic t_fifo();
    mode_10bit = 1'b0;
    tap_cfg = CLT_TAP4;
    for (int k = 0; k < 16; k++) push(mk(20 + k));
    pix_word = mk(99);
    cyc(3);
    chk("full_refuse", 64'(pix_ready), 64'h0);
    pix_valid = 1'b0;
    for (int k = 0; k < 16; k++) beat(exp_map(mk(20 + k), 1'b0, 2));
    beat('0);
    chk("drained", 64'(pix_ready), 64'h1);
  endtask

  task automatic t_trig();
    int b;
    b = n_shot;
    trigger_in_power_conn_n = 1'b0;
    cyc(8);
    trigger_in_power_conn_n = 1'b1;
    cyc(8);
    chk("shot_pwr", 64'(n_shot), 64'(b + 1));
    grabber.set_cc(1'b0);
    cyc(8);
    grabber.set_cc(1'b1);
    cyc(8);
    chk("shot_cc", 64'(n_shot), 64'(b + 2));
    grabber.set_cc(1'b0);
    trigger_in_power_conn_n = 1'b0;
    cyc(8);
    trigger_in_power_conn_n = 1'b1;
    cyc(8);
    chk("shot_blocked", 64'(n_shot), 64'(b + 2));
    grabber.set_cc(1'b1);
    cyc(8);
    chk("shot_release", 64'(n_shot), 64'(b + 3));
    cc_reserved = 3'h7;
    cyc(8);
    cc_reserved = 3'h0;
    cyc(8);
    chk("shot_reserved", 64'(n_shot), 64'(b + 3));
  endtask

  task automatic t_uart();
    logic [7:0] got;
    logic stop;
    logic sent;
    sent = 1'b0;
    tx_data = 8'ha5;
    tx_valid = 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (tx_ready === 1'b1) begin
        sent = 1'b1;
        break;
      end
    end
    #1 tx_valid = 1'b0;
    chk("tx_taken", 64'(sent), 64'h1);
    grabber.get(got, stop);
    chk("tx_byte", 64'(got), 64'ha5);
    chk("tx_stop", 64'(stop), 64'h1);
    cyc(200);
    chk("tx_ready", 64'(tx_ready), 64'h1);
    grabber.send(8'h3c, 1'b1);
    chk("rx_count", 64'(n_rx), 64'h1);
    chk("rx_byte", 64'(rx_last), 64'h3c);
    grabber.send(8'h5a, 1'b0);
    chk("rx_err", 64'(n_err), 64'h1);
    chk("rx_count_bad", 64'(n_rx), 64'h1);
  endtask

  initial begin
    rst = 1'b1;
    pix_valid = 1'b0;
    pix_word = '0;
    mode_10bit = 1'b0;
    tap_cfg = CLT_TAP1;
    trigger_in_power_conn_n = 1'b1;
    cc_reserved = 3'h0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (6) @(posedge clk_sys);
    #1 rst = 1'b0;
    cyc(1);
    t_reset();
    t_map();
    t_fifo();
    t_trig();
    t_uart();
    results();
  end

  // Whole run needs well under 10,000 cycles
  initial begin
    #400_000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
